// File: rtl/wdt_timer.v
// Watchdog timer top: special function registers, timeout flag, interrupt request and reset request
`timescale 1ns/1ps
`include "wdt_regs.vh"

module wdt_timer #(
  parameter [`WDT_CNT_W-1:0] INTERVAL_0 = `WDT_INTERVAL_0,
  parameter [`WDT_CNT_W-1:0] INTERVAL_1 = `WDT_INTERVAL_1,
  parameter [`WDT_CNT_W-1:0] INTERVAL_2 = `WDT_INTERVAL_2,
  parameter [`WDT_CNT_W-1:0] INTERVAL_3 = `WDT_INTERVAL_3
) (
  input wire clk_sys,
  input wire rst,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata,
  output reg wdt_irq_req,
  output reg wdt_irq_high_prio,
  output reg wdt_reset_req
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  reg [7:0] interrupt_enable;
  reg [7:0] extended_interrupt_enable;
  reg [7:0] extended_interrupt_priority;
  reg [7:0] clock_control_reg;
  reg timeout_irq_flag;
  reg timeout_reset_flag;
  reg reset_on_timeout_enable;
  reg count_restart_strobe;

  // Countdown between the flag and the reset request
  // Ten bits hold the 512-clock lead with room to spare
  reg delay_active;
  reg [`WDT_DELAY_W-1:0] delay_count;

  wire unlocked;
  wire timeout_tick;
  wire restart_count;
  wire [1:0] interval_select;
  wire wr_ie;
  wire wr_watchdog_control;
  wire wr_eie;
  wire wr_eip;
  wire wr_clock_control_reg;
  wire watchdog_control_write_ok;
  wire fire_reset;
  wire [7:0] watchdog_control_image;
  wire global_irq_enable;
  wire timeout_irq_enable;
  wire timeout_irq_priority;
  wire next_irq_req;

  ////////////////////////////////////////////////////////////////////////////
  // Address decoding, shared by the write and read paths
  function sfr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      sfr_hit = (addr == target);
    end
  endfunction

  assign wr_ie = sfr_wr && sfr_hit(sfr_addr, `WDT_ADDR_IE);
  assign wr_watchdog_control = sfr_wr && sfr_hit(sfr_addr, `WDT_ADDR_WATCHDOG_CONTROL);
  assign wr_eie = sfr_wr && sfr_hit(sfr_addr, `WDT_ADDR_EIE);
  assign wr_eip = sfr_wr && sfr_hit(sfr_addr, `WDT_ADDR_EIP);
  assign wr_clock_control_reg = sfr_wr && sfr_hit(sfr_addr, `WDT_ADDR_CLOCK_CONTROL_REG);

  assign watchdog_control_write_ok = wr_watchdog_control && unlocked;

  // Named bits of the enable, priority and clock registers
  assign global_irq_enable = interrupt_enable[`WDT_IE_GLOBAL];
  assign timeout_irq_enable = extended_interrupt_enable[`WDT_EIE_WDOG];
  assign timeout_irq_priority = extended_interrupt_priority[`WDT_EIP_WDOG];
  assign interval_select = clock_control_reg[`WDT_CLOCK_CONTROL_REG_SEL_HI:`WDT_CLOCK_CONTROL_REG_SEL_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Timed access key sequencer
  // The window stays open for exactly one write of any address, so an interrupt
  // routine that writes a register between the key and the control write costs
  // the caller its unlock; software must then repeat the whole sequence.

  wdt_key_gate u_key_gate (
    .clk_sys(clk_sys),
    .rst(rst),
    .sfr_wr(sfr_wr),
    .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata),
    .unlocked(unlocked)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Divider chain
  // The count never stops: with reset and interrupt both off it still ends each
  // interval and sets the flag, which is what makes the polled timer use work.
  // A watchdog reset restarts it rather than halting it.

  assign restart_count = count_restart_strobe || wdt_reset_req;

  wdt_div_chain #(
    .INTERVAL_0(INTERVAL_0),
    .INTERVAL_1(INTERVAL_1),
    .INTERVAL_2(INTERVAL_2),
    .INTERVAL_3(INTERVAL_3)
  ) u_div_chain (
    .clk_sys(clk_sys),
    .rst(rst),
    .restart(restart_count),
    .interval_select(interval_select),
    .tick(timeout_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Plain enable, priority and clock control registers
  // A watchdog reset returns them to their reset values, as it does the interrupt flag and the reset enable
  // Trade-off: the interval also falls back to its shortest code, so software that
  // relies on a long interval must program it again after such a reset.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      interrupt_enable <= `WDT_RST_IE;
      extended_interrupt_enable <= `WDT_RST_EIE;
      extended_interrupt_priority <= `WDT_RST_EIP;
      clock_control_reg <= `WDT_RST_CLOCK_CONTROL_REG;
    end
    else if (wdt_reset_req)
    begin
      interrupt_enable <= `WDT_RST_IE;
      extended_interrupt_enable <= `WDT_RST_EIE;
      extended_interrupt_priority <= `WDT_RST_EIP;
      clock_control_reg <= `WDT_RST_CLOCK_CONTROL_REG;
    end
    else
    begin
      if (wr_ie)
        interrupt_enable <= sfr_wdata;
      if (wr_eie)
        extended_interrupt_enable <= sfr_wdata;
      if (wr_eip)
        extended_interrupt_priority <= sfr_wdata;
      if (wr_clock_control_reg)
        clock_control_reg <= sfr_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timeout interrupt flag: hardware set wins over a software clear
  // Letting the set win means a timeout that lands on the clear write is never
  // lost; the worst case is one extra interrupt, which the routine tolerates.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      timeout_irq_flag <= 1'b0;
    else if (wdt_reset_req)
      timeout_irq_flag <= 1'b0;
    else if (timeout_tick)
      timeout_irq_flag <= 1'b1;
    else if (watchdog_control_write_ok)
      timeout_irq_flag <= sfr_wdata[`WDT_WATCHDOG_CONTROL_IRQF];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset-cause flag; a software set does not cause a reset
  // It must survive the reset it reports, so rst or a keyed control write clears it, never the
  // watchdog pulse; software reads it at start-up to learn why it restarted.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      timeout_reset_flag <= 1'b0;
    else if (wdt_reset_req)
      timeout_reset_flag <= 1'b1;
    else if (watchdog_control_write_ok)
      timeout_reset_flag <= sfr_wdata[`WDT_WATCHDOG_CONTROL_RSTF];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset enable and restart strobe
  // The strobe is a register bit that reads back as 1 for a single cycle only;
  // the divider sees it one cycle after the keyed write, which the timing of
  // the restart has to allow for.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      reset_on_timeout_enable <= 1'b0;
      count_restart_strobe <= 1'b0;
    end
    else if (wdt_reset_req)
    begin
      reset_on_timeout_enable <= 1'b0;
      count_restart_strobe <= 1'b0;
    end
    else
    begin
      if (watchdog_control_write_ok)
        reset_on_timeout_enable <= sfr_wdata[`WDT_WATCHDOG_CONTROL_RSTEN];
      count_restart_strobe <= watchdog_control_write_ok && sfr_wdata[`WDT_WATCHDOG_CONTROL_RESTART];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delay from the hardware timeout to the reset request
  // Only a hardware timeout arms it; setting the flag by software never resets
  // A tick that arrives while a countdown runs does not reload it, so a short
  // interval cannot postpone a reset that is already due.
  assign fire_reset = delay_active && (delay_count == 10'h001) && reset_on_timeout_enable &&
                      !count_restart_strobe;

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      delay_active <= 1'b0;
      delay_count <= 10'h000;
    end
    else if (count_restart_strobe || !reset_on_timeout_enable || wdt_reset_req)
    begin
      delay_active <= 1'b0;
      delay_count <= 10'h000;
    end
    else if (timeout_tick && !delay_active)
    begin
      delay_active <= 1'b1;
      delay_count <= `WDT_RESET_DELAY;
    end
    else if (delay_active)
    begin
      delay_count <= delay_count - 10'h001;
      if (delay_count == 10'h001)
        delay_active <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset request pulse, one cycle long
  // It must not be looped back to rst: the asynchronous reset would wipe the
  // reset-cause flag before software could read it.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      wdt_reset_req <= 1'b0;
    else
      wdt_reset_req <= fire_reset;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request and priority outputs
  // Both leave from flops, so the request trails the flag and enables by one
  // cycle; the priority output is only meaningful while the request is up.
  // three way gate
  assign next_irq_req = timeout_irq_flag && timeout_irq_enable && global_irq_enable;

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wdt_irq_req <= 1'b0;
      wdt_irq_high_prio <= 1'b0;
    end
    else
    begin
      wdt_irq_req <= next_irq_req;
      wdt_irq_high_prio <= timeout_irq_priority;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; reserved control bits and unmapped addresses read as zero
  // The enable, priority and clock registers keep all eight bits as written,
  // so spare bits there read back whatever software stored.
  assign watchdog_control_image = {4'h0, timeout_irq_flag, timeout_reset_flag, reset_on_timeout_enable,
                        count_restart_strobe};

  // Registered so the data leaves from a flop, one cycle after the read strobe
  // Reads have no side effects, so polling the control register is safe at any
  // time, even during a reset countdown.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
    begin
      if (sfr_hit(sfr_addr, `WDT_ADDR_IE))
        sfr_rdata <= interrupt_enable;
      else if (sfr_hit(sfr_addr, `WDT_ADDR_WATCHDOG_CONTROL))
        sfr_rdata <= watchdog_control_image;
      else if (sfr_hit(sfr_addr, `WDT_ADDR_EIE))
        sfr_rdata <= extended_interrupt_enable;
      else if (sfr_hit(sfr_addr, `WDT_ADDR_EIP))
        sfr_rdata <= extended_interrupt_priority;
      else if (sfr_hit(sfr_addr, `WDT_ADDR_CLOCK_CONTROL_REG))
        sfr_rdata <= clock_control_reg;
      else
        sfr_rdata <= 8'h00;
    end
  end

endmodule

// File: rtl/wdt_regs.vh
// Register offsets, bit positions, reset values and timing counts of the watchdog timer
`ifndef WDT_REGS_VH
`define WDT_REGS_VH

// Special function register addresses
`define WDT_ADDR_IE 8'hA8
`define WDT_ADDR_WATCHDOG_CONTROL 8'hD8
`define WDT_ADDR_EIE 8'hE8
`define WDT_ADDR_EIP 8'hF8
`define WDT_ADDR_KEY 8'hC7
`define WDT_ADDR_CLOCK_CONTROL_REG 8'h8E

// Reset values
`define WDT_RST_IE 8'h00
`define WDT_RST_WATCHDOG_CONTROL 8'h00
`define WDT_RST_EIE 8'h00
`define WDT_RST_EIP 8'h00
`define WDT_RST_CLOCK_CONTROL_REG 8'h03

// Field positions
`define WDT_IE_GLOBAL 7
`define WDT_EIE_WDOG 4
`define WDT_EIP_WDOG 4
`define WDT_WATCHDOG_CONTROL_IRQF 3
`define WDT_WATCHDOG_CONTROL_RSTF 2
`define WDT_WATCHDOG_CONTROL_RSTEN 1
`define WDT_WATCHDOG_CONTROL_RESTART 0
`define WDT_CLOCK_CONTROL_REG_SEL_HI 7
`define WDT_CLOCK_CONTROL_REG_SEL_LO 6

// Timed access key bytes
`define WDT_KEY_FIRST 8'hAA
`define WDT_KEY_SECOND 8'h55

// Interval counts in clocks, and the reset delay after the flag
`define WDT_CNT_W 27
`define WDT_INTERVAL_0 27'h0020000
`define WDT_INTERVAL_1 27'h0100000
`define WDT_INTERVAL_2 27'h0800000
`define WDT_INTERVAL_3 27'h4000000
`define WDT_RESET_DELAY 10'h200
`define WDT_DELAY_W 10

`endif

// File: rtl/wdt_div_chain.v
// Free-running watchdog divider chain with selectable terminal count
`timescale 1ns/1ps
`include "wdt_regs.vh"

module wdt_div_chain #(
  parameter [`WDT_CNT_W-1:0] INTERVAL_0 = `WDT_INTERVAL_0,
  parameter [`WDT_CNT_W-1:0] INTERVAL_1 = `WDT_INTERVAL_1,
  parameter [`WDT_CNT_W-1:0] INTERVAL_2 = `WDT_INTERVAL_2,
  parameter [`WDT_CNT_W-1:0] INTERVAL_3 = `WDT_INTERVAL_3
) (
  input wire clk_sys,
  input wire rst,
  input wire restart,
  input wire [1:0] interval_select,
  output reg tick
);

  reg [`WDT_CNT_W-1:0] count;
  wire [`WDT_CNT_W-1:0] limit;
  wire at_end;

  ////////////////////////////////////////////////////////////////////////////
  // Terminal count chosen by the interval code
  function [`WDT_CNT_W-1:0] wdt_limit;
    input [1:0] code;
    begin
      case (code)
        2'h0: wdt_limit = INTERVAL_0;
        2'h1: wdt_limit = INTERVAL_1;
        2'h2: wdt_limit = INTERVAL_2;
        default: wdt_limit = INTERVAL_3;
      endcase
    end
  endfunction

  assign limit = wdt_limit(interval_select);
  // Compare with >= so that shrinking the interval mid-count still ends it
  assign at_end = (count >= (limit - 27'h0000001));

  ////////////////////////////////////////////////////////////////////////////
  // Count, wrap at the interval and pulse once per elapsed interval
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      count <= 27'h0000000;
      tick <= 1'b0;
    end
    else if (restart)
    begin
      count <= 27'h0000000;
      tick <= 1'b0;
    end
    else if (at_end)
    begin
      count <= 27'h0000000;
      tick <= 1'b1;
    end
    else
    begin
      count <= count + 27'h0000001;
      tick <= 1'b0;
    end
  end

endmodule

// File: rtl/wdt_key_gate.v
// Timed access key sequencer that opens the control register for one write
`timescale 1ns/1ps
`include "wdt_regs.vh"

module wdt_key_gate (
  input wire clk_sys,
  input wire rst,
  input wire sfr_wr,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  output wire unlocked
);

  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_FIRST = 3'h2;
  localparam [2:0] ST_OPEN = 3'h4;

  reg [2:0] state;
  reg [2:0] next_state;
  wire key_wr;

  assign key_wr = sfr_wr && (sfr_addr == `WDT_ADDR_KEY);
  assign unlocked = state[2];

  ////////////////////////////////////////////////////////////////////////////
  // Only writes advance the sequence; any stray write starts it over
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (key_wr && (sfr_wdata == `WDT_KEY_FIRST))
          next_state = ST_FIRST;
      ST_FIRST:
        if (key_wr && (sfr_wdata == `WDT_KEY_SECOND))
          next_state = ST_OPEN;
        else if (key_wr && (sfr_wdata == `WDT_KEY_FIRST))
          next_state = ST_FIRST;
        else if (sfr_wr)
          next_state = ST_IDLE;
      ST_OPEN:
        // The very next write, whatever its target, uses up the window
        if (sfr_wr)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

endmodule

// File: bench/wdt_timer_chk.sv
// Port-level assertions for the watchdog timer
`timescale 1ns/1ps
module wdt_timer_chk (
  input wire clk_sys,
  input wire rst,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire sfr_rd,
  input wire [7:0] sfr_rdata,
  input wire wdt_irq_req,
  input wire wdt_irq_high_prio,
  input wire wdt_reset_req
);
  reg ie_sh;
  reg eie_sh;
  reg eip_sh;
  reg [15:0] since_rst;
  ////////////////
  // Shadow enables and priority; a watchdog reset clears them as the core does
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ie_sh <= 1'b0;
      eie_sh <= 1'b0;
      eip_sh <= 1'b0;
      since_rst <= 16'h0000;
    end
    else
    begin
      since_rst <= wdt_reset_req ? 16'h0000 : since_rst + {15'h0000, ~&since_rst}; // Saturates
      if (wdt_reset_req)
      begin
        ie_sh <= 1'b0;
        eie_sh <= 1'b0;
        eip_sh <= 1'b0;
      end
      else if (sfr_wr)
      begin
        if (sfr_addr == 8'hA8) ie_sh <= sfr_wdata[7];
        if (sfr_addr == 8'hE8) eie_sh <= sfr_wdata[4];
        if (sfr_addr == 8'hF8) eip_sh <= sfr_wdata[4];
      end
    end
  end
  ////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_global_gate: assert property (!ie_sh |=> !wdt_irq_req)
    else $error("irq with global enable off");
  a_wdog_gate: assert property (!eie_sh |=> !wdt_irq_req)
    else $error("irq with watchdog enable off");
  a_prio_copy: assert property ($changed(eip_sh) |-> ##2 wdt_irq_high_prio == eip_sh)
    else $error("priority output wrong");
  a_reset_single: assert property (wdt_reset_req |=> !wdt_reset_req)
    else $error("reset request longer than a cycle");
  a_reset_clears: assert property (wdt_reset_req |-> ##2 !wdt_irq_req && !wdt_irq_high_prio)
    else $error("state kept over watchdog reset");
  a_ie_readback: assert property (sfr_rd && sfr_addr == 8'hA8 |=> sfr_rdata[7] == ie_sh)
    else $error("global enable readback wrong");
  a_eie_readback: assert property (sfr_rd && sfr_addr == 8'hE8 |=> sfr_rdata[4] == eie_sh)
    else $error("watchdog enable readback wrong");
  // More than the 512-clock delay must pass between resets
  a_reset_spacing: assert property (wdt_reset_req |-> since_rst > 16'h0200)
    else $error("watchdog reset too early");
  cover property (wdt_reset_req);
  cover property ($rose(wdt_irq_req));
  cover property ($rose(wdt_irq_high_prio));
endmodule
bind wdt_timer wdt_timer_chk u_chk (.clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .wdt_irq_req(wdt_irq_req),
  .wdt_irq_high_prio(wdt_irq_high_prio), .wdt_reset_req(wdt_reset_req));

// File: bench/wdt_timer_tb.sv
// Self-checking testbench for the watchdog timer
`timescale 1ns/1ps
module wdt_timer_tb;
  // Shortened intervals, all above the 512-clock reset delay
  localparam [26:0] IV0 = 27'h0000280;
  localparam [26:0] IV1 = 27'h0000500;
  localparam [26:0] IV2 = 27'h0000A00;
  localparam [26:0] IV3 = 27'h0001400;
  localparam int DLY = 32'h200;
  logic clk_sys, rst, sfr_wr, sfr_rd, rd_q;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, r;
  logic wdt_irq_req, wdt_irq_high_prio, wdt_reset_req;
  logic [7:0] exp_q[$];
  logic [7:0] ad[4] = '{8'hA8, 8'hE8, 8'hF8, 8'h8E};
  int iv[4] = '{IV0, IV1, IV2, IV3};
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int n, c;
  wdt_timer #(.INTERVAL_0(IV0), .INTERVAL_1(IV1), .INTERVAL_2(IV2), .INTERVAL_3(IV3)) dut (
    .clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .wdt_irq_req(wdt_irq_req),
    .wdt_irq_high_prio(wdt_irq_high_prio), .wdt_reset_req(wdt_reset_req));
  ////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task close_out;
    if (err_total == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Strobes stay up between back-to-back transfers, so no signal is set twice per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_rd = 1'b0;
    sfr_wr = 1'b1;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic key(input logic [7:0] d);
    wr(8'hC7, 8'hAA);
    wr(8'hC7, 8'h55);
    wr(8'hD8, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    sfr_addr = a;
    sfr_wr = 1'b0;
    sfr_rd = 1'b1;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic idle(input int k);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  // Bounded wait on the interrupt (sel 0) or reset request (sel 1)
  task automatic wait_for(input bit sel, input int lim);
    n = 0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    while ((sel ? wdt_reset_req : wdt_irq_req) !== 1'b1 && n < lim)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask
  ////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Read data appears one cycle after the read edge; oldest note is compared
  always @(posedge clk_sys)
  begin
    rd_q <= sfr_rd;
    cyc <= cyc + 1;
    if (rd_q === 1'b1) check(sfr_rdata, exp_q.pop_front());
    if (cyc == 32'h9C40)
    begin
      err_total++;
      close_out();
    end
  end
  initial
  begin
    rst = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    r = 8'($urandom(50));
    repeat (10) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    rd(8'hD8, 8'h00);
    rd(8'h8E, 8'h03);
    rd(8'h01, 8'h00);
    for (c = 0; c < 4; c++)
    begin
      r = 8'($urandom);
      wr(ad[c], r);
      // The core keeps all eight bits of these registers, spare ones too
      rd(ad[c], r);
    end
    wr(8'hF8, 8'h10);
    idle(2);
    check(wdt_irq_high_prio, 1'b1);
    wr(8'hF8, 8'h00);
    // Unkeyed and interrupted key sequences leave the control register alone
    wr(8'hD8, 8'h08);
    wr(8'hC7, 8'hAA);
    wr(8'hA8, 8'h00);
    wr(8'hC7, 8'h55);
    wr(8'hD8, 8'h08);
    wr(8'hE8, 8'h10);
    rd(8'hD8, 8'h00);
    check(wdt_irq_high_prio, 1'b0);
    key(8'h08);
    idle(3);
    check(wdt_irq_req, 1'b0);
    wr(8'hE8, 8'h00);
    wr(8'hA8, 8'h80);
    idle(3);
    check(wdt_irq_req, 1'b0);
    wr(8'hE8, 8'h10);
    idle(3);
    check(wdt_irq_req, 1'b1);
    wr(8'hD8, 8'h00);
    idle(3);
    check(wdt_irq_req, 1'b1);
    key(8'h00);
    idle(3);
    check(wdt_irq_req, 1'b0);
    // Every interval code, timed from the restart strobe
    for (c = 0; c < 4; c++)
    begin
      wr(8'h8E, {c[1:0], 6'h03});
      key(8'h01);
      wait_for(1'b0, iv[c] + 20);
      check(n >= iv[c] && n <= iv[c] + 4, 1'b1);
      key(8'h00);
    end
    // Polled use with interrupt and reset off
    wr(8'hE8, 8'h00);
    wr(8'h8E, 8'h03);
    key(8'h01);
    idle(2);
    rd(8'hD8, 8'h00);
    idle(IV0 + 10);
    rd(8'hD8, 8'h08);
    check(wdt_irq_req, 1'b0);
    // A second strobe mid-count starts the interval over
    key(8'h00);
    wr(8'hE8, 8'h10);
    key(8'h01);
    idle(400);
    key(8'h01);
    wait_for(1'b0, 700);
    check(n >= IV0 && n <= IV0 + 4, 1'b1);
    // Reset armed after interval and strobe; it follows the flag by the fixed delay
    key(8'h00);
    key(8'h01);
    key(8'h02);
    wait_for(1'b0, 700);
    wait_for(1'b1, 600);
    check(n >= DLY - 3 && n <= DLY + 1, 1'b1);
    idle(1);
    rd(8'hD8, 8'h04);
    rd(8'hA8, 8'h00);
    wr(8'hA8, 8'h80);
    wr(8'hE8, 8'h10);
    wait_for(1'b0, 700);
    check(n >= IV0 - 12 && n <= IV0, 1'b1);
    // Clear the flag and arm reset, wait for a fresh timeout, then strobe in the countdown
    key(8'h02);
    idle(2);
    wait_for(1'b0, 700);
    check(n >= IV0 - 12 && n <= IV0, 1'b1);
    key(8'h03);
    wait_for(1'b1, 600);
    check(n, 600);
    close_out();
  end
endmodule
